// ==== rtl/dssl_defs.vh ====
// Register map, field positions and reset values of the debug service block
`ifndef DSSL_DEFS_VH
`define DSSL_DEFS_VH

// Byte offsets
`define DSSL_OFS_CTRL      6'h00
`define DSSL_OFS_STATUS    6'h04
`define DSSL_OFS_CLEAR     6'h08
`define DSSL_OFS_IRQ_MASK  6'h0C
`define DSSL_OFS_LENGTH    6'h10
`define DSSL_OFS_IRQ_STAT  6'h14

// Status register fields
`define DSSL_SR_BUS_ERROR_FLAG       2
`define DSSL_SR_FAIL       3
`define DSSL_SR_LCK        4
`define DSSL_SR_EN         8
`define DSSL_SR_SECURITY_LOCKDOWN_FLAG       9
`define DSSL_SR_DBG        10
`define DSSL_SR_STATE_LO   24
`define DSSL_SR_STATE_HI   26

// Control register fields
`define DSSL_CTRL_ACTIVATE_BIT         0

// Interrupt status fields
`define DSSL_IRQ_BUS_ERROR_FLAG      0
`define DSSL_IRQ_FAIL      1
`define DSSL_IRQ_LCK       2
`define DSSL_IRQ_DONE      3
`define DSSL_IRQ_W         4

// State codes
`define DSSL_ST_IDLE       3'h0
`define DSSL_ST_ERASE      3'h1
`define DSSL_ST_CRC        3'h2
`define DSSL_ST_UPAGE      3'h3

// Reset values
`define DSSL_LENGTH_RST    32'h00000000
`define DSSL_MASK_RST      4'h0

`endif

// ==== rtl/dssl_status_length.v ====
// Status, length, interrupt and AHB-Lite register slave of the debug service
// What this block does
// - Three-bit state: idle, erase, CRC32, user page read; 4-7 never shown.
// - Debugger-present bit goes to one after a falling edge on the test clock.
// - Lockdown bit shows protection; only a finished chip erase clears it.
// - With enable bit low, writes other than control are ignored.
// - Operation refused by protection sets the sticky lock-violation flag.
// - Failed operation sets sticky failure flag until cleared.
// - Inaccessible memory range sets the sticky bus-error flag.
// - Length register resets to zero; its two low bits always read zero.
//
// The AHB-Lite interface to the registers was decided locally.
`default_nettype none
`include "dssl_defs.vh"

module dssl_status_length #(
	parameter LEN_W = 32
) (
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave port
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// Test clock pin and operation engine strobes
	input  wire        tck_in,
	input  wire        op_start,
	input  wire [1:0]  op_kind,
	input  wire        op_done,
	input  wire        op_abort,
	input  wire        op_fail,
	input  wire        op_bus_err,
	input  wire        protect_set,
	// Towards the operation engine and the core
	output wire        ctrl_activate_bit,
	output wire [LEN_W-1:0] transfer_length,
	output wire        op_go,
	output reg  [2:0]  op_state,
	output wire        irq
);

	// One-hot engine states
	localparam [3:0] S_IDLE  = 4'b0001;
	localparam [3:0] S_ERASE = 4'b0010;
	localparam [3:0] S_CRC   = 4'b0100;
	localparam [3:0] S_UPAGE = 4'b1000;

	reg [3:0]        state;
	reg [3:0]        next_state;
	reg              en;
	reg              debugger_present;
	reg              tck_q;
	reg              security_lockdown_flag;
	reg [LEN_W-1:0]  len;
	reg [`DSSL_IRQ_W-1:0] irq_mask;
	reg              next_en;
	reg [LEN_W-1:0]  next_len;
	reg [`DSSL_IRQ_W-1:0] next_mask;
	reg [31:0]       next_rdata;
	reg [31:0]       status_word;
	reg              dp_wr;
	reg [5:0]        dp_addr;

	// Sticky flags and their events
	wire             lock_violation;
	wire             fail_flag;
	wire             bus_error_flag;
	wire             fail_ev;
	wire             bus_error_flag_ev;
	wire [`DSSL_IRQ_W-1:0] irq_stat;
	wire [`DSSL_IRQ_W-1:0] irq_set;
	wire [`DSSL_IRQ_W-1:0] irq_clr;

	// Bus decode
	wire             bus_take;
	wire             wr_ok;
	wire             sel_ctrl;
	wire             sel_clear;
	wire             sel_mask;
	wire             sel_len;
	wire             sel_irq;
	wire             refused;
	wire             accepted;
	wire             op_end;
	wire             clr_wr;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign bus_take  = hsel & hready & htrans[1];
	assign ctrl_activate_bit = en;
	assign transfer_length   = len;

	// Requests are refused while protected, except a chip erase
	assign refused  = op_start & state[0] & security_lockdown_flag &
		(op_kind != 2'b01);
	assign accepted = op_start & state[0] & en & ~refused;
	assign op_go    = accepted;
	assign op_end   = ~state[0] & (op_done | op_abort);
	assign wr_ok    = dp_wr & en;
	assign fail_ev  = ~state[0] & op_fail;
	assign bus_error_flag_ev  = ~state[0] & op_bus_err;

	// Data phase register selects
	assign sel_ctrl  = (dp_addr == `DSSL_OFS_CTRL);
	assign sel_clear = (dp_addr == `DSSL_OFS_CLEAR);
	assign sel_mask  = (dp_addr == `DSSL_OFS_IRQ_MASK);
	assign sel_len   = (dp_addr == `DSSL_OFS_LENGTH);
	assign sel_irq   = (dp_addr == `DSSL_OFS_IRQ_STAT);
	assign clr_wr    = wr_ok & sel_clear;

	// Interrupt events {done, lock, fail, bus error}; write one clears
	assign irq_set = {op_end, refused, fail_ev, bus_error_flag_ev};
	assign irq_clr = (wr_ok & sel_irq) ? hwdata[`DSSL_IRQ_W-1:0] :
		{`DSSL_IRQ_W{1'b0}};

	// Address phase capture
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr   <= 1'b0;
			dp_addr <= 6'h00;
		end else begin
			dp_wr   <= bus_take & hwrite;
			dp_addr <= {haddr[5:2], 2'b00};
		end
	end

	// Next engine state
	always @* begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (accepted) begin
					case (op_kind)
						2'b01:   next_state = S_ERASE;
						2'b10:   next_state = S_CRC;
						2'b11:   next_state = S_UPAGE;
						default: next_state = S_IDLE;
					endcase
				end
			end
			S_ERASE, S_CRC, S_UPAGE: begin
				if (op_done | op_abort)
					next_state = S_IDLE;
			end
			default: next_state = S_IDLE;
		endcase
	end

	// Engine state and reported code
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state    <= S_IDLE;
			op_state <= `DSSL_ST_IDLE;
		end else begin
			state <= next_state;
			case (next_state)
				S_ERASE: op_state <= `DSSL_ST_ERASE;
				S_CRC:   op_state <= `DSSL_ST_CRC;
				S_UPAGE: op_state <= `DSSL_ST_UPAGE;
				default: op_state <= `DSSL_ST_IDLE;
			endcase
		end
	end

	// Debugger detection on test clock falling edge
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tck_q            <= 1'b0;
			debugger_present <= 1'b0;
		end else begin
			tck_q <= tck_in;
			if (tck_q & ~tck_in)
				debugger_present <= 1'b1;
		end
	end

	// Protection: set by source, cleared only by completed erase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			security_lockdown_flag <= 1'b0;
		end else if (protect_set) begin
			security_lockdown_flag <= 1'b1;
		end else if (state[1] & op_done) begin
			security_lockdown_flag <= 1'b0;
		end
	end

	// Lock violation: a refused request sets it, write one clears it
	dssl_sticky dssl_sticky_lck (
		.hclk    (hclk),
		.hresetn (hresetn),
		.set_ev  (refused),
		.clr_ev  (clr_wr & hwdata[`DSSL_SR_LCK]),
		.flag    (lock_violation)
	);

	// Failure: a failing operation sets it; idle strobes are ignored
	dssl_sticky dssl_sticky_fail (
		.hclk    (hclk),
		.hresetn (hresetn),
		.set_ev  (fail_ev),
		.clr_ev  (clr_wr & hwdata[`DSSL_SR_FAIL]),
		.flag    (fail_flag)
	);

	// Bus error: part of the range could not be reached
	dssl_sticky dssl_sticky_bus_error_flag (
		.hclk    (hclk),
		.hresetn (hresetn),
		.set_ev  (bus_error_flag_ev),
		.clr_ev  (clr_wr & hwdata[`DSSL_SR_BUS_ERROR_FLAG]),
		.flag    (bus_error_flag)
	);

	// Next values of control, length and mask; length and mask writes need enable
	always @* begin
		next_en   = en;
		next_len  = len;
		next_mask = irq_mask;
		if (dp_wr & sel_ctrl)
			next_en = hwdata[`DSSL_CTRL_ACTIVATE_BIT];
		if (wr_ok & sel_len)
			next_len = {hwdata[LEN_W-1:2], 2'b00};
		if (wr_ok & sel_mask)
			next_mask = hwdata[`DSSL_IRQ_W-1:0];
	end

	// Control, length and mask registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en       <= 1'b0;
			len      <= `DSSL_LENGTH_RST;
			irq_mask <= `DSSL_MASK_RST;
		end else begin
			en       <= next_en;
			len      <= next_len;
			irq_mask <= next_mask;
		end
	end

	// Interrupt status bit: bus error event
	dssl_sticky dssl_sticky_irq0 (
		.hclk    (hclk),
		.hresetn (hresetn),
		.set_ev  (irq_set[`DSSL_IRQ_BUS_ERROR_FLAG]),
		.clr_ev  (irq_clr[`DSSL_IRQ_BUS_ERROR_FLAG]),
		.flag    (irq_stat[`DSSL_IRQ_BUS_ERROR_FLAG])
	);

	// Interrupt status bit: failure event
	dssl_sticky dssl_sticky_irq1 (
		.hclk    (hclk),
		.hresetn (hresetn),
		.set_ev  (irq_set[`DSSL_IRQ_FAIL]),
		.clr_ev  (irq_clr[`DSSL_IRQ_FAIL]),
		.flag    (irq_stat[`DSSL_IRQ_FAIL])
	);

	// Interrupt status bit: lock violation event
	dssl_sticky dssl_sticky_irq2 (
		.hclk    (hclk),
		.hresetn (hresetn),
		.set_ev  (irq_set[`DSSL_IRQ_LCK]),
		.clr_ev  (irq_clr[`DSSL_IRQ_LCK]),
		.flag    (irq_stat[`DSSL_IRQ_LCK])
	);

	// Interrupt status bit: operation finished or aborted
	dssl_sticky dssl_sticky_irq3 (
		.hclk    (hclk),
		.hresetn (hresetn),
		.set_ev  (irq_set[`DSSL_IRQ_DONE]),
		.clr_ev  (irq_clr[`DSSL_IRQ_DONE]),
		.flag    (irq_stat[`DSSL_IRQ_DONE])
	);

	// Level interrupt while any unmasked status bit is set
	assign irq = |(irq_stat & irq_mask);

	// Status word assembly; reserved bits read zero
	always @* begin
		status_word = 32'h00000000;
		status_word[`DSSL_SR_STATE_HI:`DSSL_SR_STATE_LO] = op_state;
		status_word[`DSSL_SR_DBG]  = debugger_present;
		status_word[`DSSL_SR_SECURITY_LOCKDOWN_FLAG] = security_lockdown_flag;
		status_word[`DSSL_SR_EN]   = en;
		status_word[`DSSL_SR_LCK]  = lock_violation;
		status_word[`DSSL_SR_FAIL] = fail_flag;
		status_word[`DSSL_SR_BUS_ERROR_FLAG] = bus_error_flag;
	end

	// Read data selection for the address phase being taken
	always @* begin
		case ({haddr[5:2], 2'b00})
			`DSSL_OFS_CTRL:     next_rdata = {31'h00000000, en};
			`DSSL_OFS_STATUS:   next_rdata = status_word;
			`DSSL_OFS_IRQ_MASK: next_rdata = {28'h0000000, irq_mask};
			`DSSL_OFS_LENGTH:   next_rdata = len;
			`DSSL_OFS_IRQ_STAT: next_rdata = {28'h0000000, irq_stat};
			default:            next_rdata = 32'h00000000;
		endcase
	end

	// Read data registered so it stands through the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (bus_take & ~hwrite) begin
			hrdata <= next_rdata;
		end
	end

endmodule

// Sticky flag cell: an event sets it, a write of one clears it
module dssl_sticky (
	input  wire hclk,
	input  wire hresetn,
	input  wire set_ev,
	input  wire clr_ev,
	output reg  flag
);

	// A set in the clear cycle is kept so no event is lost
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag <= 1'b0;
		end else if (set_ev) begin
			flag <= 1'b1;
		end else if (clr_ev) begin
			flag <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ==== bench/dssl_status_length_asserts.sv ====
// Port assertions for the debug service status block
`default_nettype none
module dssl_status_length_asserts #(
	parameter LEN_W = 32
) (
	input wire logic             hclk,
	input wire logic             hresetn,
	input wire logic             hsel,
	input wire logic             hready,
	input wire logic [1:0]       htrans,
	input wire logic             hwrite,
	input wire logic [1:0]       op_kind,
	input wire logic             op_done,
	input wire logic             op_abort,
	input wire logic             ctrl_activate_bit,
	input wire logic [LEN_W-1:0] transfer_length,
	input wire logic             op_go,
	input wire logic [2:0]       op_state
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Write address phase taken this cycle
	wire logic wr_ap = hsel && hready && htrans[1] && hwrite;
	a_state_legal: assert property (op_state < 3'h4)
		else $error("state code out of range");
	a_go_kind: assert property (
		op_go |=> op_state == {1'b0, $past(op_kind)})
		else $error("state not the started kind");
	a_go_enabled: assert property (
		op_go |-> ctrl_activate_bit && op_state == 3'h0)
		else $error("start taken while busy or off");
	a_end_idle: assert property (
		op_state != 3'h0 && (op_done || op_abort) |=> op_state == 3'h0)
		else $error("no return to idle");
	a_busy_hold: assert property (
		op_state != 3'h0 && !op_done && !op_abort |=> $stable(op_state))
		else $error("state moved while busy");
	a_len_words: assert property (transfer_length[1:0] == 2'h0)
		else $error("length low bits set");
	a_len_quiet: assert property (!wr_ap |=> ##1 $stable(transfer_length))
		else $error("length changed without write");
	a_off_frozen: assert property (
		!ctrl_activate_bit |=> $stable(transfer_length))
		else $error("write took effect while off");
	cover property (op_go);
	cover property (op_state != 3'h0 ##1 op_state == 3'h0);
	cover property (!ctrl_activate_bit && wr_ap);
endmodule
`default_nettype wire

// ==== bench/dssl_far.sv ====
// Far side: debugger clock and operation engine strobes
`default_nettype none
module dssl_far (
	input  wire logic       hclk,
	output var  logic       tck_in,
	output var  logic [5:0] ev,
	output var  logic [1:0] op_kind
);
	timeunit 1ns;
	timeprecision 1ps;
	// Quiet at time zero
	initial begin
		tck_in = 1'b0;
		ev = 6'h00;
		op_kind = 2'h0;
	end
	// One-cycle strobe {start,done,abort,fail,bus_error_flag,protect}
	task automatic pulse(input logic [1:0] k, input logic [5:0] v);
		op_kind <= k;
		ev <= v;
		@(posedge hclk);
		ev <= 6'h00;
		@(posedge hclk);
	endtask
	// Short clock frame; the clock rests low outside it
	task automatic tck_frame();
		repeat (4) begin
			tck_in <= ~tck_in;
			repeat (3) @(posedge hclk);
		end
	endtask
endmodule
`default_nettype wire

// ==== bench/dssl_status_length_test.sv ====
// Self-checking bench for the debug service status block
`default_nettype none
`include "dssl_defs.vh"
module dssl_status_length_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] sr_mask = 32'h0700071C;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, q, len;
	logic [5:0]  ev;
	logic [1:0]  kind;
	logic [2:0]  st;
	logic        hreadyout, hresp, tck, act, go, irq;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	always #4 hclk = ~hclk;
	dssl_far dssl_far_inst (.hclk, .tck_in(tck), .ev, .op_kind(kind));
	dssl_status_length dssl_status_length_inst (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.tck_in(tck), .op_start(ev[5]), .op_kind(kind), .op_done(ev[4]),
		.op_abort(ev[3]), .op_fail(ev[2]), .op_bus_err(ev[1]),
		.protect_set(ev[0]), .ctrl_activate_bit(act),
		.transfer_length(len), .op_go(go), .op_state(st), .irq);
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	// Bounded wait for ready at a rising edge
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 16);
		if (hreadyout !== 1'b1) begin
			n_mismatch++;
			final_report();
		end
	endtask
	// Single word transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {26'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic sr(input logic [31:0] e);
		bus(1'b0, `DSSL_OFS_STATUS, 32'h0);
		chk(q & sr_mask, e);
	endtask
	// Interrupt line once the write has landed
	task automatic chk_irq(input logic e);
		#1;
		chk({31'h0, irq}, {31'h0, e});
		@(posedge hclk);
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rd(`DSSL_OFS_LENGTH, 32'h0);
		sr(32'h0);
		bus(1'b1, `DSSL_OFS_LENGTH, 32'hFFFFFFFF);
		rd(`DSSL_OFS_LENGTH, 32'h0);
		bus(1'b1, `DSSL_OFS_CTRL, 32'h1);
		bus(1'b1, `DSSL_OFS_LENGTH, 32'hFFFFFFFF);
		bus(1'b1, 6'h3C, 32'h5);
		rd(`DSSL_OFS_LENGTH, 32'hFFFFFFFC);
		sr(32'h100);
		dssl_far_inst.tck_frame();
		sr(32'h500);
		for (int k = 1; k < 4; k++) begin
			dssl_far_inst.pulse(k[1:0], 6'h20);
			sr(32'h500 | k << 24);
			dssl_far_inst.pulse(k[1:0], k == 2 ? 6'h08 : 6'h10);
			sr(32'h500);
		end
		dssl_far_inst.pulse(2'h2, 6'h20);
		dssl_far_inst.pulse(2'h2, 6'h04);
		dssl_far_inst.pulse(2'h2, 6'h02);
		dssl_far_inst.pulse(2'h2, 6'h10);
		sr(32'h50C);
		bus(1'b1, `DSSL_OFS_CLEAR, 32'h1C);
		sr(32'h500);
		dssl_far_inst.pulse(2'h2, 6'h01);
		dssl_far_inst.pulse(2'h2, 6'h20);
		sr(32'h710);
		dssl_far_inst.pulse(2'h1, 6'h20);
		dssl_far_inst.pulse(2'h1, 6'h10);
		sr(32'h510);
		chk_irq(1'b0);
		bus(1'b1, `DSSL_OFS_IRQ_MASK, 32'h4);
		chk_irq(1'b1);
		bus(1'b1, `DSSL_OFS_IRQ_STAT, 32'h4);
		chk_irq(1'b0);
		rd(`DSSL_OFS_IRQ_STAT, 32'hB);
		final_report();
	end
endmodule
bind dssl_status_length dssl_status_length_asserts #(.LEN_W(LEN_W))
	dssl_status_length_asserts_inst (.hclk, .hresetn, .hsel, .hready,
	.htrans, .hwrite, .op_kind, .op_done, .op_abort, .ctrl_activate_bit,
	.transfer_length, .op_go, .op_state);
`default_nettype wire
